// >>> inc/frtcb_map.svh
// Register offsets, field positions, reset values and divider settings of the timer block
`ifndef FRTCB_MAP_SVH
`define FRTCB_MAP_SVH
`define FRTCB_ADDR_MODE      16'hff48
`define FRTCB_ADDR_TONE      16'hff49
`define FRTCB_ADDR_CMP_LO    16'hff4a
`define FRTCB_ADDR_CMP_HI    16'hff4b
`define FRTCB_ADDR_CNT_LO    16'hff4c
`define FRTCB_ADDR_CNT_HI    16'hff4d
`define FRTCB_ADDR_CAP_LO    16'hff4e
`define FRTCB_ADDR_CAP_HI    16'hff4f
`define FRTCB_MODE_RESET     8'h00
`define FRTCB_TONE_RESET     8'h00
`define FRTCB_CMP_RESET      16'hffff
`define FRTCB_CNT_RESET      16'h0000
`define FRTCB_BIT_OUT_LEVEL  7
`define FRTCB_BIT_OVF        6
`define FRTCB_BIT_EDGE_HI    5
`define FRTCB_BIT_EDGE_LO    4
`define FRTCB_BIT_TOGGLE_EN  3
`define FRTCB_BIT_CLK_HI     2
`define FRTCB_BIT_CLK_LO     1
`define FRTCB_BIT_OUT_EN     0
`define FRTCB_BIT_TONE_EN    0
`define FRTCB_BIT_TONE_LO    1
`define FRTCB_TONE_WR_MASK   8'h0f
`define FRTCB_DIV4_LAST      7'd3
`define FRTCB_DIV64_LAST     7'd63
`define FRTCB_DIV128_LAST    7'd127
`endif

// >>> inc/frtcb_pkg.sv
// Types shared by the timer block
`default_nettype none
package frtcb_pkg;
    typedef enum logic [1:0] {
        FRTCB_CLK_DIV4   = 2'h0,
        FRTCB_CLK_DIV64  = 2'h1,
        FRTCB_CLK_DIV128 = 2'h2,
        FRTCB_CLK_SUB    = 2'h3
    } frtcb_clk_e;
    typedef enum logic [1:0] {
        FRTCB_EDGE_OFF  = 2'h0,
        FRTCB_EDGE_RISE = 2'h1,
        FRTCB_EDGE_FALL = 2'h2,
        FRTCB_EDGE_BOTH = 2'h3
    } frtcb_edge_e;
    typedef struct packed {
        logic        toggle_en;
        frtcb_edge_e edge_sel;
        frtcb_clk_e  clk_sel;
        logic        out_en;
    } frtcb_mode_s;
    typedef struct packed {
        logic [15:0] addr;
        logic        rd;
        logic        wr;
        logic [7:0]  wdata;
    } frtcb_bus_s;
endpackage : frtcb_pkg
`default_nettype wire

// >>> verilog/frtcb_timer.sv
// Free-running 16-bit timer with compare, capture, coherent read buffer and tone output
`timescale 1ns/10ps
`default_nettype none
`include "frtcb_map.svh"

module frtcb_timer
    import frtcb_pkg::*;
(
    input  wire logic       i_mclk,
    input  wire logic       i_srst,
    input  wire logic       i_ce,
    input  wire logic       i_sub_clk,
    input  wire logic [15:0] i_addr,
    input  wire logic       i_rd,
    input  wire logic       i_wr,
    input  wire logic [7:0] i_wdata,
    output logic      [7:0] o_rdata,
    input  wire logic       i_capture_trigger_pin,
    output logic            o_match_irq,
    output logic            o_timer_out_pin,
    output logic            o_timer_out_oe,
    output logic            o_tone_pin,
    output logic            o_tone_oe
);
    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    frtcb_bus_s  bus;
    frtcb_mode_s mode;
    logic        overflow_flag;
    logic        output_level;
    logic [3:0]  tone_ctl;
    logic [15:0] compare_value;
    logic [15:0] free_running_count;
    logic [15:0] captured_count;
    logic [15:0] read_buffer;
    logic        buf_frozen;
    logic [6:0]  prescale;
    logic [2:0]  sub_sync;
    logic [1:0]  trig_sync;
    logic        trig_prev;
    logic [12:0] tone_div;
    logic        tone_wave;

    assign bus = '{addr: i_addr, rd: i_rd, wr: i_wr, wdata: i_wdata};

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire wr_mode   = bus.wr && bus.addr == `FRTCB_ADDR_MODE;
    wire wr_tone   = bus.wr && bus.addr == `FRTCB_ADDR_TONE;
    wire wr_cmp_lo = bus.wr && bus.addr == `FRTCB_ADDR_CMP_LO;
    wire wr_cmp_hi = bus.wr && bus.addr == `FRTCB_ADDR_CMP_HI;
    wire rd_cnt_lo = bus.rd && bus.addr == `FRTCB_ADDR_CNT_LO;
    wire rd_cnt_hi = bus.rd && bus.addr == `FRTCB_ADDR_CNT_HI;
    wire [1:0] wr_edge = bus.wdata[`FRTCB_BIT_EDGE_HI:`FRTCB_BIT_EDGE_LO];
    wire [1:0] wr_clk  = bus.wdata[`FRTCB_BIT_CLK_HI:`FRTCB_BIT_CLK_LO];
    frtcb_mode_s next_mode;
    // Register bit order differs from the struct order, so fields are placed by name
    assign next_mode = '{toggle_en: bus.wdata[`FRTCB_BIT_TOGGLE_EN],
                         edge_sel:  frtcb_edge_e'(wr_edge),
                         clk_sel:   frtcb_clk_e'(wr_clk),
                         out_en:    bus.wdata[`FRTCB_BIT_OUT_EN]};

    // ------------------------------------------------------------
    // Count clock
    // ------------------------------------------------------------
    // Subsystem clock is treated as a sampled input; its edge gives one tick.
    // Always synchronised here, so a tone-enabled subsystem count stays defined
    wire sub_tick = sub_sync[1] & ~sub_sync[2];
    wire [6:0] pre_last =
        (mode.clk_sel == FRTCB_CLK_DIV4)  ? `FRTCB_DIV4_LAST :
        (mode.clk_sel == FRTCB_CLK_DIV64) ? `FRTCB_DIV64_LAST : `FRTCB_DIV128_LAST;
    wire pre_tick   = (prescale & pre_last) == pre_last;
    wire count_tick = (mode.clk_sel == FRTCB_CLK_SUB) ? sub_tick : pre_tick;

    wire match      = free_running_count == compare_value;
    wire match_rise = count_tick && (free_running_count + 16'h0001) == compare_value;
    wire wrap       = count_tick && free_running_count == 16'hffff;

    // ------------------------------------------------------------
    // Capture edge
    // ------------------------------------------------------------
    wire trig_rise = trig_sync[1] & ~trig_prev;
    wire trig_fall = ~trig_sync[1] & trig_prev;
    wire capture_hit =
        (mode.edge_sel == FRTCB_EDGE_RISE && trig_rise) ||
        (mode.edge_sel == FRTCB_EDGE_FALL && trig_fall) ||
        (mode.edge_sel == FRTCB_EDGE_BOTH && (trig_rise || trig_fall));

    // ------------------------------------------------------------
    // Tone generator
    // ------------------------------------------------------------
    wire [2:0] tone_sel = tone_ctl[3:1];
    logic [3:0] tone_bit;
    always_comb begin
        unique case (tone_sel)
            3'h0: tone_bit = 4'h2;
            3'h1: tone_bit = 4'h3;
            3'h2: tone_bit = 4'h6;
            3'h3: tone_bit = 4'h7;
            3'h4: tone_bit = 4'h8;
            3'h5: tone_bit = 4'h9;
            3'h6: tone_bit = 4'ha;
            3'h7: tone_bit = 4'hb;
        endcase
    end
    wire [12:0] tone_mask = 13'((14'h0002 << tone_bit) - 14'h0001);
    wire tone_half = count_tick && ((tone_div & tone_mask) == tone_mask);

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    wire [15:0] cnt_view = buf_frozen ? read_buffer : free_running_count;
    wire [7:0]  mode_rd  = {output_level, overflow_flag, mode.edge_sel, mode.toggle_en,
                            mode.clk_sel, mode.out_en};
    wire [7:0]  next_rdata =
        (bus.addr == `FRTCB_ADDR_MODE)   ? mode_rd :
        (bus.addr == `FRTCB_ADDR_TONE)   ? {4'h0, tone_ctl} :
        (bus.addr == `FRTCB_ADDR_CMP_LO) ? compare_value[7:0] :
        (bus.addr == `FRTCB_ADDR_CMP_HI) ? compare_value[15:8] :
        (bus.addr == `FRTCB_ADDR_CNT_LO) ? free_running_count[7:0] :
        (bus.addr == `FRTCB_ADDR_CNT_HI) ? cnt_view[15:8] :
        (bus.addr == `FRTCB_ADDR_CAP_LO) ? captured_count[7:0] :
        (bus.addr == `FRTCB_ADDR_CAP_HI) ? captured_count[15:8] : 8'h00;

    // ------------------------------------------------------------
    // Sequential logic
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            mode               <= frtcb_mode_s'(6'(`FRTCB_MODE_RESET));
            overflow_flag      <= 1'b0;
            tone_ctl           <= 4'h0;
            compare_value      <= `FRTCB_CMP_RESET;
            free_running_count <= `FRTCB_CNT_RESET;
            output_level       <= 1'b0;
            prescale           <= 7'h00;
            sub_sync           <= 3'h0;
            trig_sync          <= 2'h0;
            trig_prev          <= 1'b0;
            buf_frozen         <= 1'b0;
            read_buffer        <= 16'h0000;
            tone_div           <= 13'h0000;
            tone_wave          <= 1'b0;
            o_rdata            <= 8'h00;
        end else if (i_ce) begin
            sub_sync  <= {sub_sync[1:0], i_sub_clk};
            trig_sync <= {trig_sync[0], i_capture_trigger_pin};
            trig_prev <= trig_sync[1];
            prescale  <= prescale + 7'h01;
            o_rdata   <= next_rdata;
            if (count_tick)
                free_running_count <= free_running_count + 16'h0001;
            if (wr_mode) begin
                mode <= next_mode;
                if (!bus.wdata[`FRTCB_BIT_OVF] && !wrap)
                    overflow_flag <= 1'b0;
                if (!bus.wdata[`FRTCB_BIT_OUT_EN] && !mode.out_en)
                    output_level <= 1'b0;
            end
            if (wrap)
                overflow_flag <= 1'b1;
            if (!mode.out_en)
                output_level <= 1'b0;
            else if (match_rise && mode.toggle_en)
                output_level <= ~output_level;
            if (wr_tone)
                tone_ctl <= 4'(bus.wdata & `FRTCB_TONE_WR_MASK);
            if (wr_cmp_lo)
                compare_value[7:0] <= bus.wdata;
            if (wr_cmp_hi)
                compare_value[15:8] <= bus.wdata;
            if (rd_cnt_lo) begin
                read_buffer <= free_running_count;
                buf_frozen  <= 1'b1;
            end else if (rd_cnt_hi)
                buf_frozen <= 1'b0;
            if (count_tick)
                tone_div <= tone_div + 13'h0001;
            if (!tone_ctl[`FRTCB_BIT_TONE_EN])
                tone_wave <= 1'b0;
            else if (tone_half)
                tone_wave <= ~tone_wave;
        end
    end

    // Capture has no reset: its content is undefined until the first trigger.
    always_ff @(posedge i_mclk) begin
        if (i_ce && capture_hit)
            captured_count <= free_running_count;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Request is a level while the count sits on the compare value.
    assign o_match_irq     = match && !i_srst;
    assign o_timer_out_pin = output_level;
    assign o_timer_out_oe  = mode.out_en;
    assign o_tone_pin      = tone_wave;
    assign o_tone_oe       = tone_ctl[`FRTCB_BIT_TONE_EN];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_cmp_reset_ones: assert property (@(posedge i_mclk)
        i_srst |=> compare_value == 16'hffff) else $error("compare not all ones after reset");
    a_cnt_reset_zero: assert property (@(posedge i_mclk)
        i_srst |=> free_running_count == 16'h0000) else $error("count not zero after reset");
    a_match_irq_level: assert property (@(posedge i_mclk) disable iff (i_srst)
        (i_ce && match_rise && !wr_cmp_lo && !wr_cmp_hi) |=> o_match_irq)
        else $error("match missed");
    a_count_wraps: assert property (@(posedge i_mclk) disable iff (i_srst)
        (i_ce && wrap) |=> free_running_count == 16'h0000 && overflow_flag)
        else $error("count did not wrap");
    a_out_low_off: assert property (@(posedge i_mclk) disable iff (i_srst)
        (i_ce && !mode.out_en) |=> !output_level) else $error("output not low while off");
    a_toggle_block: assert property (@(posedge i_mclk) disable iff (i_srst)
        (i_ce && !mode.toggle_en && !wr_mode) |=> $stable(output_level) || !output_level)
        else $error("output toggled while disabled");
    a_capture_load: assert property (@(posedge i_mclk) disable iff (i_srst)
        (i_ce && capture_hit) |=> captured_count == $past(free_running_count))
        else $error("capture missed");
    a_buffer_hold: assert property (@(posedge i_mclk) disable iff (i_srst)
        (i_ce && rd_cnt_lo) |=> buf_frozen && read_buffer == $past(free_running_count))
        else $error("buffer not frozen");
    a_tone_off_low: assert property (@(posedge i_mclk) disable iff (i_srst)
        (i_ce && !tone_ctl[0]) |=> !tone_wave) else $error("tone runs while off");
    c_match_seen:   cover property (@(posedge i_mclk) disable iff (i_srst) match && count_tick);
    c_capture_seen: cover property (@(posedge i_mclk) disable iff (i_srst) capture_hit);
    c_pair_read:    cover property (@(posedge i_mclk) disable iff (i_srst)
        rd_cnt_lo ##[1:8] rd_cnt_hi);
endmodule : frtcb_timer
`default_nettype wire

// >>> sim/frtcb_far_side.sv
// Far-side model: subsystem clock source and capture trigger driver
`timescale 1ns/10ps
`default_nettype none

module frtcb_far_side (
    input  wire logic i_mclk,
    output logic      o_sub_clk,
    output logic      o_trig
);
    initial begin
        o_sub_clk = 1'b0;
        o_trig    = 1'b0;
    end
    // ------------------------------------------------------------
    // Stimulus tasks
    // ------------------------------------------------------------
    // Slow pulses so the sampler catches every rising edge; idle low between
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge i_mclk) #1 o_sub_clk = 1'b1;
            repeat (4) @(posedge i_mclk);
            #1 o_sub_clk = 1'b0;
            repeat (4) @(posedge i_mclk);
        end
    endtask : tick
    // Level held long enough for sync, detect and load to finish
    task automatic set_trig(input logic lv);
        @(posedge i_mclk) #1 o_trig = lv;
        repeat (6) @(posedge i_mclk);
    endtask : set_trig
endmodule : frtcb_far_side
`default_nettype wire

// >>> sim/frtcb_timer_tb_top.sv
// Self-checking bench for the free-running timer block
`timescale 1ns/10ps
`default_nettype none
`include "frtcb_map.svh"

module frtcb_timer_tb_top
    import frtcb_pkg::*;
();
    logic        mclk;
    logic        srst;
    logic        ce;
    logic [15:0] addr;
    logic        rd;
    logic        wr;
    logic [7:0]  wdata;
    logic [7:0]  b;
    logic [7:0]  l;
    logic [15:0] cnt;
    logic [15:0] old;
    logic [15:0] cap;
    logic [15:0] v;
    logic [1:0]  e;
    wire logic [7:0] rdata;
    wire logic   sub_clk, trig, irq, tpin, toe, bpin, boe;
    int          fails      = 0;
    int          n_compared = 0;
    int          n;
    integer      seed       = 32'hfe89;

    always #20 mclk = ~mclk;

    frtcb_timer DUT (
        .i_mclk(mclk), .i_srst(srst), .i_ce(ce), .i_sub_clk(sub_clk),
        .i_addr(addr), .i_rd(rd), .i_wr(wr), .i_wdata(wdata), .o_rdata(rdata),
        .i_capture_trigger_pin(trig), .o_match_irq(irq), .o_timer_out_pin(tpin),
        .o_timer_out_oe(toe), .o_tone_pin(bpin), .o_tone_oe(boe)
    );
    frtcb_far_side far (.i_mclk(mclk), .o_sub_clk(sub_clk), .o_trig(trig));
    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        n_compared++;
        if (seen !== want) begin
            fails++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, want);
        end
    endtask : check
    task automatic finish_test();
        $display("compared %0d mismatched %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test
    task automatic wr8(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk) #1;
        addr  = a;
        wdata = d;
        wr    = 1'b1;
        @(posedge mclk) #1 wr = 1'b0;
    endtask : wr8
    task automatic rd8(input logic [15:0] a, output logic [7:0] d);
        @(posedge mclk) #1;
        addr = a;
        rd   = 1'b1;
        @(posedge mclk) #1 rd = 1'b0;
        d = rdata;
    endtask : rd8
    // Low byte always first, high byte right after
    task automatic rd16(input logic [15:0] a, output logic [15:0] d);
        rd8(a, d[7:0]);
        rd8(a + 16'h0001, d[15:8]);
    endtask : rd16
    task automatic wr16(input logic [15:0] a, input logic [15:0] d);
        wr8(a, d[7:0]);
        wr8(a + 16'h0001, d[15:8]);
    endtask : wr16
    task automatic tone_edge(output int cyc);
        logic lv;
        lv  = bpin;
        cyc = 0;
        while (bpin === lv) begin
            @(posedge mclk) #1;
            cyc++;
            if (cyc > 40000) begin
                fails++;
                finish_test();
            end
        end
    endtask : tone_edge
    function automatic logic [7:0] mode(input logic [1:0] ed, input logic t,
                                        input logic [1:0] k, input logic o);
        return {2'b00, ed, t, k, o};
    endfunction : mode
    function automatic int half_ticks(input int c);
        return (c < 2) ? (8 << c) : (128 << (c - 2));
    endfunction : half_ticks
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        mclk  = 1'b0;
        srst  = 1'b1;
        ce    = 1'b1;
        addr  = 16'h0000;
        rd    = 1'b0;
        wr    = 1'b0;
        wdata = 8'h00;
        repeat (16) @(posedge mclk);
        #1 srst = 1'b0;
        rd8(`FRTCB_ADDR_MODE, b);
        check({8'h00, b}, {8'h00, `FRTCB_MODE_RESET});
        rd8(`FRTCB_ADDR_TONE, b);
        check({8'h00, b}, {8'h00, `FRTCB_TONE_RESET});
        rd16(`FRTCB_ADDR_CMP_LO, v);
        check(v, `FRTCB_CMP_RESET);
        rd8(16'hff50, b);
        check({8'h00, b}, 16'h0000);
        check({14'h0, toe, boe}, 16'h0000);
        $display("test reset done");
        // Subsystem clock makes the count fully predictable from the bench
        wr8(`FRTCB_ADDR_MODE, mode(FRTCB_EDGE_OFF, 1'b0, FRTCB_CLK_SUB, 1'b0));
        rd16(`FRTCB_ADDR_CNT_LO, cnt);
        check({6'h0, cnt[15:6]}, 16'h0000);
        for (int i = 0; i < 3; i++) begin
            n = ($random(seed) & 31) + 1;
            far.tick(n);
            cnt += 16'(n);
            rd16(`FRTCB_ADDR_CNT_LO, v);
            check(v, cnt);
        end
        rd8(`FRTCB_ADDR_CNT_LO, l);
        old = cnt;
        far.tick(300);
        cnt += 16'd300;
        rd8(`FRTCB_ADDR_CNT_HI, b);
        check({b, l}, old);
        rd16(`FRTCB_ADDR_CNT_LO, v);
        check(v, cnt);
        $display("test count done");
        // With the enable low neither count ticks nor bus writes may land
        ce = 1'b0;
        far.tick(4);
        wr8(`FRTCB_ADDR_CMP_LO, 8'h5a);
        ce = 1'b1;
        rd16(`FRTCB_ADDR_CNT_LO, v);
        check(v, cnt);
        rd16(`FRTCB_ADDR_CMP_LO, v);
        check(v, `FRTCB_CMP_RESET);
        $display("test freeze done");
        for (int i = 0; i < 4; i++) begin
            e = 2'(i + 1);
            wr8(`FRTCB_ADDR_MODE, mode(e, 1'b0, FRTCB_CLK_SUB, 1'b0));
            n = ($random(seed) & 7) + 1;
            far.tick(n);
            cnt += 16'(n);
            far.set_trig(1'b1);
            if (e[0]) cap = cnt;
            far.tick(2);
            cnt += 16'd2;
            far.set_trig(1'b0);
            if (e[1]) cap = cnt;
            rd16(`FRTCB_ADDR_CAP_LO, v);
            check(v, cap);
        end
        $display("test capture done");
        wr16(`FRTCB_ADDR_CMP_LO, cnt + 16'd3);
        check({15'h0, irq}, 16'h0000);
        wr8(`FRTCB_ADDR_MODE, mode(FRTCB_EDGE_OFF, 1'b1, FRTCB_CLK_SUB, 1'b1));
        @(posedge mclk) #1;
        check({14'h0, toe, tpin}, 16'h0002);
        far.tick(3);
        cnt += 16'd3;
        check({14'h0, irq, tpin}, 16'h0003);
        rd8(`FRTCB_ADDR_MODE, b);
        check({8'h00, b}, 16'h008f);
        wr8(`FRTCB_ADDR_MODE, mode(FRTCB_EDGE_OFF, 1'b0, FRTCB_CLK_SUB, 1'b1));
        wr16(`FRTCB_ADDR_CMP_LO, cnt + 16'd2);
        rd16(`FRTCB_ADDR_CMP_LO, v);
        check(v, cnt + 16'd2);
        far.tick(2);
        cnt += 16'd2;
        check({14'h0, irq, tpin}, 16'h0003);
        rd16(`FRTCB_ADDR_CNT_LO, v);
        check(v, cnt);
        $display("test output done");
        wr8(`FRTCB_ADDR_MODE, mode(FRTCB_EDGE_OFF, 1'b0, FRTCB_CLK_DIV4, 1'b0));
        for (int c = 0; c < 8; c++) begin
            wr8(`FRTCB_ADDR_TONE, {4'h0, 3'(c), 1'b1});
            rd8(`FRTCB_ADDR_TONE, b);
            check({8'h00, b}, {12'h000, 3'(c), 1'b1});
            check({15'h0, boe}, 16'h0001);
            tone_edge(n);
            tone_edge(n);
            check(16'(n), 16'(half_ticks(c) * 4));
        end
        wr8(`FRTCB_ADDR_TONE, 8'h00);
        @(posedge mclk) #1;
        check({15'h0, boe}, 16'h0000);
        $display("test tone done");
        finish_test();
    end
endmodule : frtcb_timer_tb_top
`default_nettype wire
